// *** design/dsa_defines.svh ***
// constants for the dual-slope converter sequencer
`ifndef DSA_DEFINES_SVH
`define DSA_DEFINES_SVH
`define DSA_CYCLE_COUNTS 13'd8000
`define DSA_INT_COUNTS 13'd2000
`define DSA_FULL_SCALE 13'd4000
`define DSA_CLEAR_COUNTS 13'd400
`define DSA_MIN_NULL 13'd1600
`define DSA_CONV_DIV 10'd4
`define DSA_BP_DIV 10'd768
`endif

// *** design/dsa_pkg.sv ***
// types for the dual-slope converter sequencer
package dsa_pkg;
	typedef enum logic [1:0] {
		DSA_NULL,
		DSA_INTEG,
		DSA_DEINT,
		DSA_CLEAR
	} dsa_phase_t;
endpackage : dsa_pkg

// *** design/dsa_divider.sv ***
// free-running clock divider giving a square wave and a wrap pulse
`timescale 1ns/1ps
`default_nettype none
module dsa_divider #(
	parameter logic [9:0] DIV = 10'd4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// divided outputs
	output logic sq_out,
	output logic wrap
);
	typedef struct packed {
		logic [9:0] cnt;
		logic sq;
		logic wrap;
	} dsa_div_st_t;
	dsa_div_st_t s_r, s_nxt;
	always_comb begin
		s_nxt = s_r;
		s_nxt.wrap = 1'b0;
		if (s_r.cnt == DIV - 10'd1) begin
			s_nxt.cnt = 10'h0;
			s_nxt.wrap = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt + 10'h1;
		end
		s_nxt.sq = (s_nxt.cnt >= (DIV >> 1));
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
	assign sq_out = s_r.sq;
	assign wrap = s_r.wrap;
endmodule : dsa_divider
`default_nettype wire

// *** design/dsa_sequencer.sv ***
// dual-slope conversion sequencer, clock dividers and display latch
`timescale 1ns/1ps
`default_nettype none
`include "dsa_defines.svh"
module dsa_sequencer (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// analog front end
	input wire logic comp_pos,
	output logic sw_inp_common,
	output logic sw_inn_common,
	output logic sw_input_pins,
	output logic sw_ref_pos,
	output logic sw_ref_neg,
	output logic sw_int_clear,
	output dsa_pkg::dsa_phase_t phase,
	// static selects
	input wire logic point_select_low,
	input wire logic point_select_high,
	input wire logic hold,
	// display side
	output logic [12:0] reading,
	output logic reading_neg,
	output logic overrange,
	output logic [2:0] point_on,
	output logic count_tick,
	output logic conv_clk,
	output logic backplane_clk
);
	import dsa_pkg::*;

	typedef struct packed {
		logic tick;
		dsa_phase_t ph;
		logic [12:0] cyc;
		logic [12:0] pcnt;
		logic neg;
		logic ovr;
		logic [12:0] disp;
		logic disp_neg;
		logic disp_ovr;
		logic [2:0] pts;
		logic [5:0] sw;
	} dsa_st_t;
	dsa_st_t s_r, s_nxt;
	logic conv_sq, bp_sq;

	// converter drive, oscillator / 4
	dsa_divider #(.DIV(`DSA_CONV_DIV)) u_conv (
		.clk(clk),
		.rst_n(rst_n),
		.sq_out(conv_sq),
		.wrap()
	);
	// backplane, oscillator / 768
	dsa_divider #(.DIV(`DSA_BP_DIV)) u_bp (
		.clk(clk),
		.rst_n(rst_n),
		.sq_out(bp_sq),
		.wrap()
	);

	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = ~s_r.tick;
		// point segments are static, never gated by freeze
		case ({point_select_high, point_select_low})
			2'b00: s_nxt.pts = 3'b000;
			2'b01: s_nxt.pts = 3'b001;
			2'b10: s_nxt.pts = 3'b010;
			2'b11: s_nxt.pts = 3'b100;
			default: s_nxt.pts = 3'b000;
		endcase
		if (s_r.tick) begin
			s_nxt.cyc = (s_r.cyc == `DSA_CYCLE_COUNTS - 13'd1) ?
				13'h0 : s_r.cyc + 13'h1;
			s_nxt.pcnt = s_r.pcnt + 13'h1;
			case (s_r.ph)
				DSA_NULL: begin
					// null absorbs leftovers: it ends only at cycle wrap
					if (s_r.cyc == `DSA_CYCLE_COUNTS - 13'd1) begin
						s_nxt.ph = DSA_INTEG;
						s_nxt.pcnt = 13'h0;
					end
				end
				DSA_INTEG: begin
					if (s_r.pcnt == `DSA_INT_COUNTS - 13'd1) begin
						s_nxt.ph = DSA_DEINT;
						s_nxt.pcnt = 13'h0;
						// comparator high means input drove integrator negative
						s_nxt.neg = comp_pos;
					end
				end
				DSA_DEINT: begin
					if (s_r.pcnt == `DSA_FULL_SCALE - 13'd1 ||
						s_r.pcnt != 13'h0 && comp_pos != s_r.neg) begin
						// count is 2000*vin/vref; runs out at twice reference
						s_nxt.ovr = (comp_pos == s_r.neg);
						s_nxt.ph = s_nxt.ovr ? DSA_CLEAR : DSA_NULL;
						s_nxt.pcnt = 13'h0;
						if (!hold) begin
							s_nxt.disp = s_nxt.ovr ? `DSA_FULL_SCALE :
								s_r.pcnt + 13'h1;
							s_nxt.disp_neg = s_r.neg;
							s_nxt.disp_ovr = s_nxt.ovr;
						end
					end
				end
				DSA_CLEAR: begin
					if (s_r.pcnt == `DSA_CLEAR_COUNTS - 13'd1) begin
						s_nxt.ph = DSA_NULL;
						s_nxt.pcnt = 13'h0;
					end
				end
				default: s_nxt.ph = DSA_NULL;
			endcase
		end
		// switch image: inp_com, inn_com, pins, ref_pos, ref_neg, clear
		case (s_nxt.ph)
			DSA_NULL: s_nxt.sw = 6'b110000;
			DSA_INTEG: s_nxt.sw = 6'b001000;
			DSA_DEINT: s_nxt.sw = s_nxt.neg ? 6'b010100 : 6'b010010;
			DSA_CLEAR: s_nxt.sw = 6'b000001;
			default: s_nxt.sw = 6'b110000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.ph <= DSA_NULL;
			s_r.cyc <= `DSA_CYCLE_COUNTS - `DSA_MIN_NULL;
			s_r.sw <= 6'b110000;
		end else begin
			s_r <= s_nxt;
		end
	end

	// output flops
	logic conv_r, bp_r;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			conv_r <= 1'b0;
			bp_r <= 1'b0;
		end else begin
			conv_r <= conv_sq;
			bp_r <= bp_sq;
		end
	end
	assign conv_clk = conv_r;
	assign backplane_clk = bp_r;
	assign count_tick = s_r.tick;
	assign phase = s_r.ph;
	assign {sw_inp_common, sw_inn_common, sw_input_pins, sw_ref_pos,
		sw_ref_neg, sw_int_clear} = s_r.sw;
	assign reading = s_r.disp;
	assign reading_neg = s_r.disp_neg;
	assign overrange = s_r.disp_ovr;
	assign point_on = s_r.pts;

	// checks
	a_cycle_start: assert property (@(posedge clk) disable iff (!rst_n)
		s_r.tick && s_r.cyc == 13'd7999 |=> s_r.ph == DSA_INTEG)
		else $error("integration does not start at cycle wrap");
	a_null_switch: assert property (@(posedge clk) disable iff (!rst_n)
		s_r.ph == DSA_NULL |-> sw_inp_common && sw_inn_common
		&& !sw_input_pins)
		else $error("inputs not on common in null phase");
	a_deint_neg: assert property (@(posedge clk) disable iff (!rst_n)
		s_r.ph == DSA_DEINT |-> sw_inn_common
		&& (sw_ref_pos != sw_ref_neg))
		else $error("deintegration switch image wrong");
	a_tick_half: assert property (@(posedge clk) disable iff (!rst_n)
		count_tick |=> !count_tick)
		else $error("count tick not at half rate");
	a_int_len: assert property (@(posedge clk) disable iff (!rst_n)
		s_r.ph == DSA_INTEG && s_r.tick && s_r.pcnt == 13'd1999
		|=> s_r.ph == DSA_DEINT)
		else $error("integration length wrong");
	a_hold_frz: assert property (@(posedge clk) disable iff (!rst_n)
		hold |=> $stable(reading))
		else $error("reading changed while held");
	a_hold_frz_ovr: assert property (@(posedge clk) disable iff (!rst_n)
		hold |=> $stable(overrange) && $stable(reading_neg))
		else $error("status changed while held");
	a_point_map: assert property (@(posedge clk) disable iff (!rst_n)
		{point_select_high, point_select_low} == 2'b10
		|=> point_on == 3'b010)
		else $error("point decode wrong");
	a_over_full: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(overrange) |-> reading == 13'd4000)
		else $error("overrange without full scale");
	a_min_null: assert property (@(posedge clk) disable iff (!rst_n)
		s_r.cyc >= 13'd6400 |-> s_r.ph == DSA_NULL)
		else $error("null window wrong");
	c_overrange: cover property (@(posedge clk) $rose(overrange));
	c_negative: cover property (@(posedge clk) $rose(reading_neg));
	c_clear: cover property (@(posedge clk) s_r.ph == DSA_CLEAR);
	c_hold: cover property (@(posedge clk) hold && s_r.ph == DSA_DEINT);
endmodule : dsa_sequencer
`default_nettype wire

// *** verif/dsa_front_model.sv ***
// integrator and comparator model facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module dsa_front_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// sequencer side
	input wire logic count_tick,
	input wire dsa_pkg::dsa_phase_t phase,
	output logic comp_pos,
	// scenario control
	input wire logic sign_neg,
	input wire logic [12:0] target
);
	import dsa_pkg::*;
	logic [12:0] ticks_r;
	always_ff @(posedge clk) begin
		if (!rst_n || phase != DSA_DEINT)
			ticks_r <= 13'h0;
		else if (count_tick)
			ticks_r <= ticks_r + 13'h1;
	end
	// ramp reaches zero after target ticks; a large target never crosses
	assign comp_pos = sign_neg ^ (phase == DSA_DEINT && ticks_r >= target);
endmodule : dsa_front_model
`default_nettype wire

// *** verif/dual_slope_adc_sequencer_tb.sv ***
// self-checking bench for the dual-slope sequencer
`timescale 1ns/1ps
`default_nettype none
module dual_slope_adc_sequencer_tb;
	import dsa_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, comp_pos, sel_lo = 1'b0, sel_hi = 1'b0;
	logic hold = 1'b0, sign_neg = 1'b0;
	logic [12:0] target = 13'h3e8, reading;
	logic neg, ovr, tick, cclk, bclk, s_p, s_n, s_in, s_rp, s_rn, s_cl;
	logic [2:0] pt;
	dsa_phase_t phase;
	int n_fail = 0, num_checks = 0, since = 0, cyc_len = 0, cnt;
	logic integ_q = 1'b0, prev;
	// row: sign, hold, model target, then expected reading, negative, over
	logic [29:0] rows [5] = '{{1'b0, 1'b0, 13'h3e8, 13'h3e9, 1'b0, 1'b0},
		{1'b1, 1'b0, 13'h7cf, 13'h7d0, 1'b1, 1'b0},
		{1'b0, 1'b0, 13'hfa0, 13'hfa0, 1'b0, 1'b1},
		{1'b1, 1'b1, 13'h00a, 13'hfa0, 1'b0, 1'b1},
		{1'b0, 1'b0, 13'h063, 13'h064, 1'b0, 1'b0}};
	dsa_sequencer dut (.clk(clk), .rst_n(rst_n), .comp_pos(comp_pos),
		.sw_inp_common(s_p), .sw_inn_common(s_n), .sw_input_pins(s_in),
		.sw_ref_pos(s_rp), .sw_ref_neg(s_rn), .sw_int_clear(s_cl),
		.phase(phase), .point_select_low(sel_lo), .point_select_high(sel_hi),
		.hold(hold), .reading(reading), .reading_neg(neg), .overrange(ovr),
		.point_on(pt), .count_tick(tick), .conv_clk(cclk),
		.backplane_clk(bclk));
	dsa_front_model front (.clk(clk), .rst_n(rst_n), .count_tick(tick),
		.phase(phase), .comp_pos(comp_pos), .sign_neg(sign_neg),
		.target(target));
	initial begin
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		integ_q <= (phase == DSA_INTEG);
		since <= since + 1;
		if (phase == DSA_INTEG && !integ_q) begin
			cyc_len <= since;
			since <= 1;
		end
	end
	task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: value %0h, expected %0h", $time, got, exp);
		end
	endtask : chk_v
	task automatic chk_b(input logic got, input logic exp);
		chk_v({15'h0, got}, {15'h0, exp});
	endtask : chk_b
	task automatic wait_phase(input dsa_phase_t p);
		int k;
		for (k = 0; k < 20000 && phase !== p; k++)
			@(negedge clk);
		chk_b(phase === p, 1'b1);
	endtask : wait_phase
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	// sel 0 converter drive, 1 backplane, otherwise count tick
	task automatic count_rises(input int span, input int sel, output int c);
		logic cur;
		c = 0;
		prev = (sel == 0) ? cclk : (sel == 1) ? bclk : tick;
		repeat (span) begin
			@(negedge clk);
			cur = (sel == 0) ? cclk : (sel == 1) ? bclk : tick;
			if (cur && !prev)
				c++;
			prev = cur;
		end
	endtask : count_rises
	// five cycles of 16000 clocks plus start-up and divider tests
	initial begin
		#(25ns * 90000);
		n_fail++;
		print_verdict();
	end
	initial begin
		repeat (6) @(negedge clk);
		chk_v({3'h0, reading}, 16'h0);
		rst_n = 1'b1;
		foreach (rows[i]) begin
			{sign_neg, hold, target} = rows[i][29:15];
			wait_phase(DSA_DEINT);
			chk_b(s_rp, sign_neg);
			chk_b(s_rn, !sign_neg);
			chk_b(s_n, 1'b1);
			chk_b(s_in, 1'b0);
			if (target >= 13'd4000) begin
				wait_phase(DSA_CLEAR);
				chk_b(s_cl, 1'b1);
			end
			wait_phase(DSA_NULL);
			repeat (2) @(negedge clk);
			chk_b(s_p & s_n, 1'b1);
			chk_b(s_cl, 1'b0);
			chk_v({3'h0, reading}, {3'h0, rows[i][14:2]});
			chk_b(neg, rows[i][1]);
			chk_b(ovr, rows[i][0]);
			hold = 1'b0;
			$display("conversion row %0d done", i);
		end
		chk_v(cyc_len[15:0], 16'd16000);
		for (int i = 0; i < 4; i++) begin
			{sel_hi, sel_lo} = i[1:0];
			repeat (2) @(negedge clk);
			chk_v({13'h0, pt}, (i == 0) ? 16'h0 : 16'h1 << (i - 1));
		end
		count_rises(1536, 0, cnt);
		chk_v(cnt[15:0], 16'd384);
		count_rises(1536, 1, cnt);
		chk_v(cnt[15:0], 16'd2);
		count_rises(100, 2, cnt);
		chk_v(cnt[15:0], 16'd50);
		$display("divider and point tests done");
		rst_n = 1'b0;
		@(negedge clk);
		chk_v({3'h0, reading}, 16'h0);
		chk_b(phase === DSA_NULL, 1'b1);
		chk_b(s_p & s_n, 1'b1);
		$display("reset test done");
		print_verdict();
	end
endmodule : dual_slope_adc_sequencer_tb
`default_nettype wire
